// >>> rtl/bcrs_top.sv
// Report store writer and instruction sequencer for the bus controller
`timescale 1ns/1ps
`default_nettype none
module bcrs_top #(
  parameter int GAP_CYCLES = bcrs_pkg::GAP_CYC,
  parameter int ST_TIMEOUT_CYCLES = bcrs_pkg::ST_TIMEOUT_CYC,
  parameter int CNT_W = 17
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Subsystem sequencing pins
  input wire logic halt_request_n,
  output logic halted_ack_n,
  output logic table_advance_strobe_n,
  output logic interrupt_request_n,
  // Store addressing and write data
  output logic store_select_n,
  output logic direction_select_n,
  output logic location_bit_low,
  output logic location_bit_high,
  output logic store_write_n,
  output logic [15:0] store_wdata,
  // Message engine events, same clock
  output logic exec_start,
  output logic exec_abort,
  input wire logic msg_done,
  input wire logic retry_start,
  input wire logic int_always,
  input wire logic int_cond,
  input wire logic self_test,
  input wire logic bus_sel,
  input wire logic noop_instr,
  input wire logic tx_active,
  input wire logic tx_timeout,
  input wire logic loop_fail,
  input wire logic cmd_error,
  input wire logic wc_low,
  input wire logic wc_high,
  input wire logic tx_missing,
  input wire logic rx_missing,
  input wire logic tx_stat_bad,
  input wire logic rx_stat_bad,
  input wire logic rx_status_valid,
  input wire logic [15:0] rx_status,
  input wire logic tx_status_valid,
  input wire logic [15:0] tx_status,
  input wire logic [15:0] rx_cmd,
  input wire logic [15:0] tx_cmd,
  input wire logic xfer_req,
  input wire logic xfer_is_tx,
  input wire logic xfer_ack,
  input wire logic bus_data_word,
  input wire logic bus_cmd_stat_word,
  input wire logic bus_quiet
);
  // ==========================================================
  // Pin synchroniser
  logic hr_s1_q, hr_s1_d, hr_s2_q, hr_s2_d;
  always_comb begin
    hr_s1_d = halt_request_n;
    hr_s2_d = hr_s1_q;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hr_s1_q <= 1'b0;
      hr_s2_q <= 1'b0;
    end else begin
      hr_s1_q <= hr_s1_d;
      hr_s2_q <= hr_s2_d;
    end
  end

  // Saturating counter step
  function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
    inc_sat = (&v) ? v : v + 1'b1;
  endfunction

  // ==========================================================
  // Report flags
  bcrs_pkg::bcrs_state_t st_q, st_d;
  logic [15:0] rep_q, rep_d, rxs_q, rxs_d, txs_q, txs_d;
  logic [CNT_W-1:0] ack_q, ack_d, st_cnt_q, st_cnt_d, busy_q, busy_d;
  logic irq_evt_q, irq_evt_d;
  logic hs_fail, st_fail, busy_bus, new_cycle, clr_msg;
  always_comb begin
    new_cycle = (st_q == bcrs_pkg::S_ARMED) && (st_d == bcrs_pkg::S_EXEC);
    clr_msg = new_cycle || retry_start;
    // Acknowledge timer, limit depends on direction
    ack_d = xfer_req && !xfer_ack ? inc_sat(ack_q) : '0;
    hs_fail = xfer_req && !xfer_ack &&
      (ack_q >= CNT_W'(xfer_is_tx ? bcrs_pkg::TX_ACK_CYC
                                  : bcrs_pkg::RX_ACK_CYC));
    // Self test timeout watchdog
    st_cnt_d = (self_test && st_q == bcrs_pkg::S_EXEC) ? inc_sat(st_cnt_q) : '0;
    st_fail = self_test && (st_cnt_q == CNT_W'(ST_TIMEOUT_CYCLES));
    // Contiguous data word run after a command or status word
    busy_d = busy_q;
    if (bus_quiet || bus_cmd_stat_word) busy_d = '0;
    else if (bus_data_word) busy_d = inc_sat(busy_q);
    busy_bus = busy_q > CNT_W'(bcrs_pkg::BUSY_WORDS);
    rep_d = rep_q;
    if (new_cycle) begin
      rep_d[bcrs_pkg::B_PROG_HALT] = 1'b0;
      rep_d[bcrs_pkg::B_RETRY] = 1'b0;
      rep_d[bcrs_pkg::B_CMD_ERR] = 1'b0;
    end
    if (clr_msg) begin
      rep_d[bcrs_pkg::B_WC_LOW] = 1'b0;
      rep_d[bcrs_pkg::B_WC_HIGH] = 1'b0;
      rep_d[bcrs_pkg::B_TX_MISS] = 1'b0;
      rep_d[bcrs_pkg::B_RX_MISS] = 1'b0;
      rep_d[bcrs_pkg::B_TX_FLAG] = 1'b0;
      rep_d[bcrs_pkg::B_RX_FLAG] = 1'b0;
    end
    if (bus_quiet) rep_d[bcrs_pkg::B_TRAFFIC] = 1'b0;
    // Sets follow clears so a same-cycle event wins
    if (st_q == bcrs_pkg::S_EXEC) begin
      if ((tx_timeout && tx_active) || st_fail) begin
        rep_d[bcrs_pkg::B_TX_TIMEOUT] = 1'b1;
      end
      if (tx_timeout || st_fail) begin
        rep_d[bus_sel ? bcrs_pkg::B_TO_BUS1 : bcrs_pkg::B_TO_BUS0] = 1'b1;
      end
      if (hs_fail) rep_d[bcrs_pkg::B_HANDSHAKE] = 1'b1;
      if (loop_fail && tx_active) rep_d[bcrs_pkg::B_LOOP] = 1'b1;
      if (int_always) rep_d[bcrs_pkg::B_PROG_HALT] = 1'b1;
      if (retry_start) rep_d[bcrs_pkg::B_RETRY] = 1'b1;
      if (wc_low) rep_d[bcrs_pkg::B_WC_LOW] = 1'b1;
      if (wc_high) rep_d[bcrs_pkg::B_WC_HIGH] = 1'b1;
      if (cmd_error) rep_d[bcrs_pkg::B_CMD_ERR] = 1'b1;
      if (tx_missing) rep_d[bcrs_pkg::B_TX_MISS] = 1'b1;
      if (rx_missing) rep_d[bcrs_pkg::B_RX_MISS] = 1'b1;
      if (tx_stat_bad) rep_d[bcrs_pkg::B_TX_FLAG] = 1'b1;
      if (rx_stat_bad) rep_d[bcrs_pkg::B_RX_FLAG] = 1'b1;
    end
    if (new_cycle && busy_bus) rep_d[bcrs_pkg::B_TRAFFIC] = 1'b1;
  end

  // ==========================================================
  // Status copies and interrupt cause latch
  always_comb begin
    rxs_d = rxs_q;
    txs_d = txs_q;
    irq_evt_d = new_cycle ? 1'b0 : irq_evt_q;
    // self test copies commands at fetch
    if (new_cycle && self_test) begin
      rxs_d = rx_cmd;
      txs_d = tx_cmd;
    end else begin
      if (rx_status_valid) rxs_d = rx_status;
      if (tx_status_valid) txs_d = tx_status;
    end
    if (st_q == bcrs_pkg::S_EXEC) begin
      if (int_always || int_cond || cmd_error || hs_fail || st_fail ||
          (loop_fail && tx_active) || (tx_timeout && tx_active)) begin
        irq_evt_d = 1'b1;
      end
    end
    if (new_cycle && busy_bus) irq_evt_d = 1'b1;
  end

  // ==========================================================
  // Sequencer
  logic [CNT_W-1:0] cnt_q, cnt_d, irq_cnt_q, irq_cnt_d;
  logic first_q, first_d, hr_prev_q, hr_prev_d, adv_q, adv_d;
  logic wr_q, wr_d, abort_q, abort_d, start_q, start_d;
  logic [1:0] loc_q, loc_d;
  logic [15:0] wdata_q, wdata_d;
  logic dir_q, dir_d, sel_n_q, sel_n_d;
  logic skip_q, skip_d, irq_n_q, irq_n_d, hlt_n_q, hlt_n_d;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    first_d = first_q;
    hr_prev_d = hr_s2_q;
    adv_d = 1'b1;
    wr_d = 1'b1;
    sel_n_d = 1'b1;
    dir_d = 1'b1;
    loc_d = loc_q;
    wdata_d = wdata_q;
    start_d = 1'b0;
    abort_d = 1'b0;
    skip_d = skip_q;
    irq_cnt_d = (irq_cnt_q != '0) ? irq_cnt_q - 1'b1 : '0;
    case (st_q)
      bcrs_pkg::S_HALTED: begin
        // rising request must stay high long enough
        cnt_d = '0;
        if (hr_s2_q && !hr_prev_q) st_d = bcrs_pkg::S_ARMED;
      end
      bcrs_pkg::S_ARMED: begin
        cnt_d = inc_sat(cnt_q);
        if (!hr_s2_q) st_d = bcrs_pkg::S_HALTED;
        else if (cnt_q >= CNT_W'(bcrs_pkg::HALT_REQ_CYC - 1)) begin
          st_d = bcrs_pkg::S_EXEC;
          start_d = !first_q && !busy_bus;
          // Nothing started, so execution ends at once
          skip_d = first_q || busy_bus;
          first_d = 1'b0;
        end
      end
      bcrs_pkg::S_EXEC: begin
        sel_n_d = 1'b0;
        abort_d = hs_fail || cmd_error || st_fail ||
          (tx_active && loop_fail);
        if (msg_done || noop_instr || abort_d || skip_q) begin
          st_d = bcrs_pkg::S_WR_REP;
        end
        cnt_d = '0;
      end
      bcrs_pkg::S_WR_REP: begin
        sel_n_d = 1'b0;
        dir_d = 1'b0;
        wr_d = 1'b0;
        loc_d = bcrs_pkg::LOC_REPORT;
        wdata_d = rep_q;
        st_d = bcrs_pkg::S_WR_RX;
      end
      bcrs_pkg::S_WR_RX: begin
        sel_n_d = 1'b0;
        dir_d = 1'b0;
        wr_d = 1'b0;
        loc_d = bcrs_pkg::LOC_RX_STATUS;
        wdata_d = rxs_q;
        st_d = bcrs_pkg::S_WR_TX;
      end
      bcrs_pkg::S_WR_TX: begin
        sel_n_d = 1'b0;
        dir_d = 1'b0;
        wr_d = 1'b0;
        loc_d = bcrs_pkg::LOC_TX_STATUS;
        wdata_d = txs_q;
        if (irq_evt_q) begin
          irq_cnt_d = CNT_W'(bcrs_pkg::IRQ_CYC);
          st_d = bcrs_pkg::S_HALTED;
        end else if (hr_s2_q) begin
          adv_d = 1'b0;
          st_d = bcrs_pkg::S_GAP;
        end else begin
          st_d = bcrs_pkg::S_HALTED;
        end
      end
      bcrs_pkg::S_GAP: begin
        cnt_d = inc_sat(cnt_q);
        if (cnt_q >= CNT_W'(GAP_CYCLES - 1)) begin
          cnt_d = CNT_W'(bcrs_pkg::HALT_REQ_CYC);
          st_d = bcrs_pkg::S_ARMED;
        end
      end
      default: st_d = bcrs_pkg::S_HALTED;
    endcase
    // Interrupt pin follows its counter
    irq_n_d = (irq_cnt_d == '0);
    // halted lags the state so the last write ends first
    hlt_n_d = (st_q != bcrs_pkg::S_HALTED);
  end

  // Register everything; outputs come straight from flops
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= bcrs_pkg::S_HALTED;
      rep_q <= bcrs_pkg::REPORT_RST;
      rxs_q <= 16'h0000;
      txs_q <= 16'h0000;
      ack_q <= '0;
      st_cnt_q <= '0;
      busy_q <= '0;
      irq_evt_q <= 1'b0;
      cnt_q <= '0;
      irq_cnt_q <= '0;
      first_q <= 1'b1;
      hr_prev_q <= 1'b1;
      adv_q <= 1'b1;
      wr_q <= 1'b1;
      abort_q <= 1'b0;
      start_q <= 1'b0;
      loc_q <= 2'h0;
      wdata_q <= 16'h0000;
      dir_q <= 1'b1;
      sel_n_q <= 1'b1;
      skip_q <= 1'b0;
      irq_n_q <= 1'b1;
      hlt_n_q <= 1'b0;
    end else begin
      st_q <= st_d;
      rep_q <= rep_d;
      rxs_q <= rxs_d;
      txs_q <= txs_d;
      ack_q <= ack_d;
      st_cnt_q <= st_cnt_d;
      busy_q <= busy_d;
      irq_evt_q <= irq_evt_d;
      cnt_q <= cnt_d;
      irq_cnt_q <= irq_cnt_d;
      first_q <= first_d;
      hr_prev_q <= hr_prev_d;
      adv_q <= adv_d;
      wr_q <= wr_d;
      abort_q <= abort_d;
      start_q <= start_d;
      loc_q <= loc_d;
      wdata_q <= wdata_d;
      dir_q <= dir_d;
      sel_n_q <= sel_n_d;
      skip_q <= skip_d;
      irq_n_q <= irq_n_d;
      hlt_n_q <= hlt_n_d;
    end
  end

  // Output mapping, pin named halt_request_n is the active-high request
  always_comb begin
    halted_ack_n = hlt_n_q;
    table_advance_strobe_n = adv_q;
    interrupt_request_n = irq_n_q;
    store_select_n = sel_n_q;
    direction_select_n = dir_q;
    location_bit_low = loc_q[0];
    location_bit_high = loc_q[1];
    store_write_n = wr_q;
    store_wdata = wdata_q;
    exec_start = start_q;
    exec_abort = abort_q;
  end
endmodule
`default_nettype wire

// >>> rtl/bcrs_pkg.sv
// Constants, report bit layout and states for the report and sequencing block
package bcrs_pkg;
  // ==========================================================
  // Clock and times
  localparam int CLK_MHZ = 100;
  localparam int HALT_REQ_MIN_NS = 1000;
  localparam int IRQ_PULSE_NS = 250;
  localparam int GAP_US = 20;
  localparam int ST_TIMEOUT_US = 800;
  localparam int RX_ACK_NS = 750;
  localparam int TX_ACK_NS = 13500;
  localparam int HALT_REQ_CYC = (HALT_REQ_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int IRQ_CYC = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC = GAP_US * CLK_MHZ;
  localparam int ST_TIMEOUT_CYC = ST_TIMEOUT_US * CLK_MHZ;
  localparam int RX_ACK_CYC = RX_ACK_NS * CLK_MHZ / 1000;
  localparam int TX_ACK_CYC = TX_ACK_NS * CLK_MHZ / 1000;
  localparam int BUSY_WORDS = 32;
  // ==========================================================
  // Report store locations
  localparam logic [1:0] LOC_REPORT = 2'h0;
  localparam logic [1:0] LOC_RX_STATUS = 2'h1;
  localparam logic [1:0] LOC_TX_STATUS = 2'h2;
  // ==========================================================
  // Report word bit positions
  // fixed flag bits
  localparam int B_TX_TIMEOUT = 0;
  localparam int B_HANDSHAKE = 1;
  localparam int B_LOOP = 2;
  localparam int B_PROG_HALT = 3;
  localparam int B_RETRY = 4;
  localparam int B_WC_LOW = 5;
  localparam int B_WC_HIGH = 6;
  localparam int B_CMD_ERR = 7;
  localparam int B_TX_MISS = 8;
  localparam int B_TX_FLAG = 9;
  localparam int B_RX_MISS = 10;
  localparam int B_RX_FLAG = 11;
  localparam int B_TO_BUS0 = 12;
  localparam int B_TO_BUS1 = 13;
  localparam int B_TRAFFIC = 14;
  localparam logic [15:0] REPORT_RST = 16'h0000;
  // ==========================================================
  // Sequencer states
  typedef enum logic [6:0] {
    S_HALTED = 7'h01,
    S_ARMED = 7'h02,
    S_EXEC = 7'h04,
    S_WR_REP = 7'h08,
    S_WR_RX = 7'h10,
    S_WR_TX = 7'h20,
    S_GAP = 7'h40
  } bcrs_state_t;
endpackage

// >>> sim/bcrs_properties.sv
// Port checker for the report and sequencing block
`timescale 1ns/1ps
`default_nettype none
module bcrs_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sequencing pins
  input wire logic halted_ack_n,
  input wire logic table_advance_strobe_n,
  input wire logic interrupt_request_n,
  input wire logic exec_start,
  // Store pins
  input wire logic store_select_n,
  input wire logic direction_select_n,
  input wire logic location_bit_low,
  input wire logic location_bit_high,
  input wire logic store_write_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ==========================================
  // Report store write steps
  sequence s_wr(h, l);
    !store_write_n && location_bit_high == h && location_bit_low == l;
  endsequence
  property p_no_loc3;
    !store_select_n |-> !(location_bit_low && location_bit_high);
  endproperty
  a_no_loc3: assert property (p_no_loc3)
    else $error("fourth store location addressed");
  property p_wr_dir;
    !store_write_n |-> !store_select_n && !direction_select_n;
  endproperty
  a_wr_dir: assert property (p_wr_dir)
    else $error("write not aimed at report store");
  property p_wr_ord;
    s_wr(0, 0) |=> s_wr(0, 1) ##1 s_wr(1, 0);
  endproperty
  a_wr_ord: assert property (p_wr_ord)
    else $error("report writes out of order");
  property p_irq_rep;
    $fell(interrupt_request_n) |->
      $past(!store_write_n && !location_bit_high && !location_bit_low, 2);
  endproperty
  a_irq_rep: assert property (p_irq_rep)
    else $error("interrupt without report word first");
  property p_irq_len;
    $fell(interrupt_request_n) |-> (!interrupt_request_n)[*8] ##17
      !interrupt_request_n ##1 interrupt_request_n;
  endproperty
  a_irq_len: assert property (p_irq_len)
    else $error("interrupt pulse not 25 cycles");
  property p_stb_one;
    $fell(table_advance_strobe_n) |=> table_advance_strobe_n;
  endproperty
  a_stb_one: assert property (p_stb_one)
    else $error("advance strobe longer than one cycle");
  property p_stb_irq;
    !table_advance_strobe_n |-> interrupt_request_n &&
      $past(interrupt_request_n);
  endproperty
  a_stb_irq: assert property (p_stb_irq)
    else $error("advance strobe beside interrupt");
  property p_gap;
    $rose(table_advance_strobe_n) |-> (!exec_start)[*8];
  endproperty
  a_gap: assert property (p_gap)
    else $error("next message started inside gap");
  property p_ack;
    exec_start || !store_write_n |-> halted_ack_n;
  endproperty
  a_ack: assert property (p_ack)
    else $error("halted shown while executing");
endmodule
`default_nettype wire

// >>> sim/bcrs_subsys_model.sv
// Subsystem model: halt request, transfer acknowledge, report store
`timescale 1ns/1ps
`default_nettype none
module bcrs_subsys_model #(
  parameter int HOLD = 103
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bench controls
  input wire logic go,
  input wire logic cont,
  input wire logic [7:0] ack_delay,
  // Sequencing and transfer pins
  input wire logic xfer_req,
  output logic halt_request_n,
  output logic xfer_ack,
  // Report store side
  input wire logic store_select_n,
  input wire logic direction_select_n,
  input wire logic location_bit_low,
  input wire logic location_bit_high,
  input wire logic store_write_n,
  input wire logic [15:0] store_wdata,
  output logic [2:0][15:0] mem
);
  int hold_q = 0;
  int ack_q = 0;
  logic [2:0][15:0] mem_q = {3{16'hFFFF}};
  assign mem = mem_q;
  // request held clean
  // Registered so it never glitches; held just past the minimum
  always_ff @(posedge clk) begin
    if (go) hold_q <= HOLD;
    else if (hold_q > 0) hold_q <= hold_q - 1;
    halt_request_n <= go || cont || hold_q > 1;
  end
  // Acknowledge once after the programmed delay
  always_ff @(posedge clk) begin
    ack_q <= xfer_req ? ack_q + 1 : 0;
    xfer_ack <= xfer_req && ack_q == int'(ack_delay);
  end
  // Capture report store writes, fourth location ignored
  always_ff @(posedge clk) begin
    if (!store_select_n && !store_write_n && !direction_select_n &&
        !(location_bit_high && location_bit_low))
      mem_q[{location_bit_high, location_bit_low}] <= store_wdata;
  end
endmodule
`default_nettype wire

// >>> sim/tb_bcrs_top.sv
// Self-checking bench for the report and sequencing block
`timescale 1ns/1ps
`default_nettype none
module tb_bcrs_top;
  // ==========================================
  // Bench signals
  localparam int GAP = 20;
  logic clk = 1'b0, resetn = 1'b0, go = 1'b0, cont = 1'b0;
  logic msg_done = 1'b0, xfer_req = 1'b0, xfer_is_tx = 1'b0, wrote = 1'b0;
  logic dw = 1'b0, csw = 1'b0;
  logic [7:0] ack_delay = 8'h05;
  logic [18:0] ev = 19'h00000;
  logic [15:0] rx_st = 16'h0000, tx_st = 16'h0000, sticky = 16'h0000;
  logic halt_request_n, halted_ack_n, table_advance_strobe_n, xfer_ack;
  logic interrupt_request_n, store_select_n, direction_select_n;
  logic location_bit_low, location_bit_high, store_write_n;
  logic exec_start, exec_abort;
  logic [15:0] store_wdata;
  logic [2:0][15:0] mem;
  int bad_count = 0, checks = 0, starts = 0, aborts = 0;
  int irqc = 0, stbc = 0, cyc = 0, t_stb = 0, t_go = 0;
  // Free running clock
  always #5 clk = ~clk;
  // Pulse tallies, kept here so late pulses are never missed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (exec_start) starts <= starts + 1;
    if (exec_start) t_go <= cyc;
    if (exec_abort) aborts <= aborts + 1;
    if (!interrupt_request_n) irqc <= irqc + 1;
    if (!table_advance_strobe_n) stbc <= stbc + 1;
    if (!table_advance_strobe_n) t_stb <= cyc;
    if (!store_write_n && location_bit_high) wrote <= 1'b1;
  end
  // ==========================================
  // Design and subsystem model
  bcrs_top #(.GAP_CYCLES(GAP), .ST_TIMEOUT_CYCLES(50)) DUT (
    .clk, .resetn, .halt_request_n, .halted_ack_n, .table_advance_strobe_n,
    .interrupt_request_n, .store_select_n, .direction_select_n,
    .location_bit_low, .location_bit_high, .store_write_n, .store_wdata,
    .exec_start, .exec_abort, .msg_done, .retry_start(ev[0]),
    .int_always(ev[2]), .int_cond(ev[1]), .self_test(ev[14]),
    .bus_sel(ev[15]), .noop_instr(ev[16]), .tx_active(ev[12]),
    .tx_timeout(ev[11]), .loop_fail(ev[10]), .cmd_error(ev[9]),
    .wc_low(ev[8]), .wc_high(ev[7]), .tx_missing(ev[6]), .rx_missing(ev[4]),
    .tx_stat_bad(ev[5]), .rx_stat_bad(ev[3]), .rx_status_valid(ev[18]),
    .rx_status(rx_st), .tx_status_valid(ev[17]), .tx_status(tx_st),
    .rx_cmd(16'h1111), .tx_cmd(16'h2222), .xfer_req, .xfer_is_tx,
    .xfer_ack, .bus_data_word(dw), .bus_cmd_stat_word(csw),
    .bus_quiet(ev[13]));
  bcrs_subsys_model MODEL (.clk, .resetn, .go, .cont, .ack_delay, .xfer_req,
    .halt_request_n, .xfer_ack, .store_select_n, .direction_select_n,
    .location_bit_low, .location_bit_high, .store_write_n, .store_wdata,
    .mem);
  // ==========================================
  // Compare, wait and verdict
  task automatic cmp(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return exec_start;
      1: return wrote;
      default: return xfer_ack;
    endcase
  endfunction
  // Bounded wait; a hang ends the run
  task automatic wait_c(input int k, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      #1;
      if (cond(k) === 1'b1) return;
    end
    cmp("wait", 16'(k), 16'hFFFF);
    finish_test();
  endtask
  // Request one instruction that ends by itself, wait past its report
  task automatic kick;
    @(posedge clk) go <= 1'b1;
    wrote <= 1'b0;
    @(posedge clk) go <= 1'b0;
    wait_c(1, 300);
    repeat (30) @(posedge clk);
    #1;
  endtask
  // One message: start, events, optional transfer, end, report
  task automatic do_msg(input logic [18:0] e1, e2, input logic [7:0] dly,
      input logic ab, irq, input logic [15:0] x);
    int a0, i0, s0;
    a0 = aborts;
    i0 = irqc;
    s0 = stbc;
    @(posedge clk) go <= 1'b1;
    wrote <= 1'b0;
    @(posedge clk) go <= 1'b0;
    wait_c(0, 300);
    @(posedge clk) ev <= e1;
    @(posedge clk) ev <= e2;
    ack_delay <= dly;
    xfer_req <= (dly != 8'h00);
    if (dly != 8'h00) wait_c(2, 150);
    @(posedge clk) xfer_req <= 1'b0;
    if (!ab) repeat (10) @(posedge clk);
    msg_done <= !ab;
    @(posedge clk) msg_done <= 1'b0;
    ev <= 19'h00000;
    wait_c(1, 300);
    repeat (40) @(posedge clk);
    #1;
    cmp("report", x | sticky, mem[0]);
    cmp("irq cycles", irq ? 16'h0019 : 16'h0000, 16'(irqc - i0));
    cmp("strobes", 16'(cont), 16'(stbc - s0));
    cmp("aborts", 16'(ab), 16'(aborts - a0));
    if (!cont) cmp("halted", 16'h0000, 16'(halted_ack_n));
    // Reset-only bits stay set in later reports
    sticky = sticky | (x & 16'h3007);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    int n0, i0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    kick();
    cmp("starts", 16'h0000, 16'(starts));
    cmp("report", 16'h0000, mem[0]);
    @(posedge clk) rx_st <= 16'hA5C3;
    tx_st <= 16'h3C5A;
    do_msg(19'h00000, 19'h60000, 8'h00, 1'b0, 1'b0, 16'h0000);
    cmp("rx status", rx_st, mem[1]);
    cmp("tx status", tx_st, mem[2]);
    do_msg(19'h00000, 19'h00004, 8'h00, 1'b0, 1'b1, 16'h0008);
    do_msg(19'h00000, 19'h10000, 8'h00, 1'b0, 1'b0, 16'h0000);
    do_msg(19'h000F8, 19'h00103, 8'h00, 1'b0, 1'b1, 16'h0030);
    do_msg(19'h00000, 19'h00200, 8'h00, 1'b1, 1'b1, 16'h0080);
    do_msg(19'h00000, 19'h01400, 8'h00, 1'b1, 1'b1, 16'h0004);
    do_msg(19'h00000, 19'h09800, 8'h00, 1'b0, 1'b1, 16'h2001);
    do_msg(19'h00000, 19'h00000, 8'h64, 1'b1, 1'b1, 16'h0002);
    @(posedge clk) xfer_is_tx <= 1'b1;
    do_msg(19'h00000, 19'h00000, 8'h05, 1'b0, 1'b0, 16'h0000);
    @(posedge clk) cont <= 1'b1;
    do_msg(19'h00000, 19'h00000, 8'h00, 1'b0, 1'b0, 16'h0000);
    cmp("gap", 16'h0001, 16'(t_go - t_stb >= GAP));
    @(posedge clk) cont <= 1'b0;
    wrote <= 1'b0;
    repeat (10) @(posedge clk);
    msg_done <= 1'b1;
    @(posedge clk) msg_done <= 1'b0;
    wait_c(1, 50);
    repeat (5) @(posedge clk);
    #1;
    cmp("halted", 16'h0000, 16'(halted_ack_n));
    // Self test that ends on its timeout; fetch copies the commands
    @(posedge clk) ev <= 19'h04000;
    kick();
    cmp("report", 16'h1001 | sticky, mem[0]);
    cmp("rx status", 16'h1111, mem[1]);
    cmp("tx status", 16'h2222, mem[2]);
    sticky = sticky | 16'h1001;
    // Command word then a long data run makes the bus busy
    @(posedge clk) ev <= 19'h00000;
    csw <= 1'b1;
    @(posedge clk) csw <= 1'b0;
    dw <= 1'b1;
    repeat (40) @(posedge clk);
    n0 = starts;
    i0 = irqc;
    kick();
    cmp("starts", 16'(n0), 16'(starts));
    cmp("report", 16'h4000 | sticky, mem[0]);
    cmp("irq cycles", 16'h0019, 16'(irqc - i0));
    // Quiet bus clears the traffic bit before the next message
    @(posedge clk) dw <= 1'b0;
    ev <= 19'h02000;
    do_msg(19'h00000, 19'h00000, 8'h00, 1'b0, 1'b0, 16'h0000);
    // Mid-run reset clears sticky bits; next fetch is a no-op again
    @(posedge clk) resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    n0 = starts;
    kick();
    cmp("starts", 16'(n0), 16'(starts));
    cmp("report", 16'h0000, mem[0]);
    finish_test();
  end
endmodule
bind bcrs_top bcrs_checker CHK (.*);
`default_nettype wire
